//--- core/sarseq_consts.svh
// register addresses, field positions, reset values and counts of the converter sequencer
`ifndef SARSEQ_CONSTS_SVH
`define SARSEQ_CONSTS_SVH
// ==========================================
// register addresses on the sfr bus
`define SARSEQ_ADDR_PAIR 8'hba
`define SARSEQ_ADDR_CHSEL 8'hbb
`define SARSEQ_ADDR_CFG 8'hbc
`define SARSEQ_ADDR_RESL 8'hbe
`define SARSEQ_ADDR_RESH 8'hbf
`define SARSEQ_ADDR_CTRL 8'he8
// ==========================================
// control register bit positions
`define SARSEQ_CTRL_EN 7
`define SARSEQ_CTRL_TM 6
`define SARSEQ_CTRL_DONE 5
`define SARSEQ_CTRL_BUSY 4
`define SARSEQ_CTRL_SRC_HI 3
`define SARSEQ_CTRL_SRC_LO 2
`define SARSEQ_CTRL_WIN 1
`define SARSEQ_CTRL_LJST 0
// config register fields
`define SARSEQ_CFG_PERIOD_HI 7
`define SARSEQ_CFG_PERIOD_LO 3
`define SARSEQ_CFG_GAIN_HI 2
// ==========================================
// reset values
`define SARSEQ_RST_CTRL 8'h00
`define SARSEQ_RST_CFG 8'hf8
`define SARSEQ_RST_PAIR 4'h0
`define SARSEQ_RST_CHSEL 4'h0
// ==========================================
// start source codes
`define SARSEQ_SRC_SW 2'h0
`define SARSEQ_SRC_T3 2'h1
`define SARSEQ_SRC_EXT 2'h2
`define SARSEQ_SRC_T2 2'h3
// ==========================================
// counts in converter clocks, mux codes
`define SARSEQ_TRACK_SAR_CLKS 5'h03
`define SARSEQ_CONV_SAR_CLKS 5'h10
`define SARSEQ_MUX_TEMP 4'h8
`endif

//--- core/sarseq_pkg.sv
// types shared by the converter sequencer modules
package sarseq_pkg;
  // ==========================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONV
  } sarseq_fsm_type;

  // ==========================================
  // converter clock divider state
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } sarseq_div_type;

  // ==========================================
  // sequencer state, registers and outputs
  typedef struct packed {
    sarseq_fsm_type state;
    logic [4:0] cnt;
    logic converter_enable;
    logic track_mode_sel;
    logic conv_done_flag;
    logic [1:0] start_src;
    logic win_flag;
    logic left_justify;
    logic [7:0] cfg;
    logic [3:0] pair_cfg;
    logic [3:0] chan_addr;
    logic [11:0] result;
    logic result_diff;
    logic [2:0] sync;
    logic ext_lvl;
    logic [7:0] rdata;
    logic analog_en;
    logic track;
    logic convert;
    logic [3:0] mux_pos;
    logic [3:0] mux_neg;
    logic mux_diff;
    logic mux_temp;
    logic irq;
    logic busy_out;
  } sarseq_state_type;
endpackage

//--- core/sarseq_clkdiv.sv
// converter clock tick generator dividing the system clock
`include "sarseq_consts.svh"
module sarseq_clkdiv
  import sarseq_pkg::*;
(
  // system
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [4:0] period_i,
  // tick
  output logic tick_o
);
  sarseq_div_type st_q;
  sarseq_div_type st_d;

  // one tick every period+1 system clocks; restarted at each conversion for a fixed phase
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run_i) begin
      st_d.cnt = 5'h00;
    end else if (st_q.cnt == period_i) begin
      st_d.cnt = 5'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 5'h01;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;

  property p_div_tick;
    @(posedge clk_sys_i) disable iff (rst_i)
    (run_i && st_q.cnt == period_i) |=> tick_o;
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("divider tick missing");
endmodule // sarseq_clkdiv

//--- core/sarseq_top.sv
// digital sequencer and input mux control of the 12-bit converter
// How it works
// - conversion starts from one selected source: software, timer 3, pin edge, timer 2.
// - busy stays high through the whole conversion, low once it finishes.
// - busy falling sets the done flag and, if enabled, the interrupt request.
// - result sits in high and low registers, left or right aligned.
// - converter clock is the system clock divided by the period field plus one.
// - track mode zero tracks continuously whenever no conversion runs.
// - track mode one tracks three converter clocks after the start event.
// - low-power mode with pin source tracks while pin low, converts on rise.
// - tracking is shut down while the chip is in standby or sleep.
// - each pair bit makes its inputs single-ended or an even-positive pair.
// - differential results come out in two's complement.
// - upper four bits of both mux registers read zero, ignore writes.
// - codes 0 to 7 pick inputs or their pair, top bit picks temperature.
// - temperature selection routes the sensor to the amplifier input.
// - analog parts stay shut down unless the enable bit is one.
// - start field codes 00 software, 01 timer 3, 10 pin, 11 timer 2.
// - period field equals system clock over converter clock minus one.
`include "sarseq_consts.svh"
module sarseq_top
  import sarseq_pkg::*;
(
  // system
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // special function register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // start sources and chip state
  input wire logic timer3_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic ext_convert_start_i,
  input wire logic standby_i,
  input wire logic irq_enable_i,
  // analog converter core
  input wire logic [11:0] conv_data_i,
  output logic analog_enable_o,
  output logic track_o,
  output logic convert_o,
  output logic sar_tick_o,
  // input mux and amplifier
  output logic [3:0] mux_pos_o,
  output logic [3:0] mux_neg_o,
  output logic mux_diff_o,
  output logic mux_temp_o,
  output logic [2:0] pga_gain_o,
  // status
  output logic conv_irq_o,
  output logic conv_busy_o
);
  sarseq_state_type st_q;
  sarseq_state_type st_d;
  logic tick;
  logic busy;
  logic busy_next;
  logic ext_rise;
  logic sw_start;
  logic start_evt;
  logic diffsel;
  logic done_set;
  logic ctrl_wr;
  // ==========================================
  // converter clock divider, running only while tracking or converting
  sarseq_clkdiv u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .run_i(st_q.state != ST_IDLE),
    .period_i(st_q.cfg[`SARSEQ_CFG_PERIOD_HI:`SARSEQ_CFG_PERIOD_LO]),
    .tick_o(tick)
  );
  // ==========================================
  // next state
  always_comb begin
    st_d = st_q;
    busy = (st_q.state == ST_TRACK) || (st_q.state == ST_CONV);
    ctrl_wr = sfr_wr_i && (sfr_addr_i == `SARSEQ_ADDR_CTRL);
    // pin: three flops, a level counts once second and third agree
    st_d.sync = {st_q.sync[1:0], ext_convert_start_i};
    if (st_q.sync[1] == st_q.sync[2]) begin
      st_d.ext_lvl = st_q.sync[2];
    end
    ext_rise = (st_q.sync[1] == st_q.sync[2]) && st_q.sync[2] && !st_q.ext_lvl;
    // a busy write only starts when the same write leaves the source at software
    sw_start = ctrl_wr && sfr_wdata_i[`SARSEQ_CTRL_BUSY]
      && (sfr_wdata_i[`SARSEQ_CTRL_SRC_HI:`SARSEQ_CTRL_SRC_LO] == `SARSEQ_SRC_SW);
    // start source select
    case (st_q.start_src)
      `SARSEQ_SRC_SW: start_evt = sw_start;
      `SARSEQ_SRC_T3: start_evt = timer3_ovf_i;
      `SARSEQ_SRC_EXT: start_evt = ext_rise;
      `SARSEQ_SRC_T2: start_evt = timer2_ovf_i;
      default: start_evt = 1'b0;
    endcase
    // mux decode; an odd code in a differential pair maps to the pair
    diffsel = !st_q.chan_addr[3] && st_q.pair_cfg[st_q.chan_addr[2:1]];
    // sequencer
    case (st_q.state)
      ST_IDLE: begin
        if (st_q.converter_enable && start_evt) begin
          st_d.cnt = 5'h00;
          // pin source in low-power mode has already tracked while low
          if (st_q.track_mode_sel && (st_q.start_src != `SARSEQ_SRC_EXT)) begin
            st_d.state = ST_TRACK;
          end else begin
            st_d.state = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (tick) begin
          if (st_q.cnt == `SARSEQ_TRACK_SAR_CLKS - 5'h01) begin
            st_d.cnt = 5'h00;
            st_d.state = ST_CONV;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (st_q.cnt == `SARSEQ_CONV_SAR_CLKS - 5'h01) begin
            st_d.state = ST_IDLE;
            st_d.result = conv_data_i;
            st_d.result_diff = diffsel;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
      end
      default: st_d.state = ST_IDLE;
    endcase
    // disabling aborts the sequence
    if (!st_q.converter_enable) begin
      st_d.state = ST_IDLE;
    end
    busy_next = (st_d.state == ST_TRACK) || (st_d.state == ST_CONV);
    done_set = busy && !busy_next;
    // register writes; upper mux bits are simply not stored
    if (ctrl_wr) begin
      st_d.converter_enable = sfr_wdata_i[`SARSEQ_CTRL_EN];
      st_d.track_mode_sel = sfr_wdata_i[`SARSEQ_CTRL_TM];
      st_d.start_src = sfr_wdata_i[`SARSEQ_CTRL_SRC_HI:`SARSEQ_CTRL_SRC_LO];
      st_d.win_flag = sfr_wdata_i[`SARSEQ_CTRL_WIN];
      st_d.left_justify = sfr_wdata_i[`SARSEQ_CTRL_LJST];
    end
    if (sfr_wr_i && (sfr_addr_i == `SARSEQ_ADDR_CFG)) begin
      st_d.cfg = sfr_wdata_i;
    end
    if (sfr_wr_i && (sfr_addr_i == `SARSEQ_ADDR_PAIR)) begin
      st_d.pair_cfg = sfr_wdata_i[3:0];
    end
    if (sfr_wr_i && (sfr_addr_i == `SARSEQ_ADDR_CHSEL)) begin
      st_d.chan_addr = sfr_wdata_i[3:0];
    end
    // set wins over a software clear in the same cycle
    if (ctrl_wr) begin
      st_d.conv_done_flag = sfr_wdata_i[`SARSEQ_CTRL_DONE] | done_set;
    end else begin
      st_d.conv_done_flag = st_q.conv_done_flag | done_set;
    end
    // registered read data, justification applied at read time
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        `SARSEQ_ADDR_CTRL: st_d.rdata = {st_q.converter_enable, st_q.track_mode_sel,
          st_q.conv_done_flag, busy, st_q.start_src, st_q.win_flag, st_q.left_justify};
        `SARSEQ_ADDR_CFG: st_d.rdata = st_q.cfg;
        `SARSEQ_ADDR_PAIR: st_d.rdata = {4'h0, st_q.pair_cfg};
        `SARSEQ_ADDR_CHSEL: st_d.rdata = {4'h0, st_q.chan_addr};
        `SARSEQ_ADDR_RESH: st_d.rdata = st_q.left_justify ? st_q.result[11:4]
          : {{4{st_q.result_diff & st_q.result[11]}}, st_q.result[11:8]};
        `SARSEQ_ADDR_RESL: st_d.rdata = st_q.left_justify ? {st_q.result[3:0], 4'h0}
          : st_q.result[7:0];
        default: st_d.rdata = 8'h00;
      endcase
    end
    // registered outputs, one cycle behind the state
    st_d.analog_en = st_q.converter_enable;
    st_d.track = st_q.converter_enable && !standby_i && ((st_q.state == ST_TRACK)
      || ((st_q.state == ST_IDLE) && (!st_q.track_mode_sel
      || ((st_q.start_src == `SARSEQ_SRC_EXT) && !st_q.ext_lvl))));
    st_d.convert = st_q.state == ST_CONV;
    st_d.mux_temp = st_q.chan_addr[3];
    st_d.mux_diff = diffsel;
    if (st_q.chan_addr[3]) begin
      st_d.mux_pos = `SARSEQ_MUX_TEMP;
      st_d.mux_neg = 4'h0;
    end else if (diffsel) begin
      st_d.mux_pos = {1'b0, st_q.chan_addr[2:1], 1'b0};
      st_d.mux_neg = {1'b0, st_q.chan_addr[2:1], 1'b1};
    end else begin
      st_d.mux_pos = st_q.chan_addr;
      st_d.mux_neg = 4'h0;
    end
    st_d.irq = st_q.conv_done_flag && irq_enable_i;
    st_d.busy_out = busy;
  end
  // ==========================================
  // state register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.state <= ST_IDLE;
      st_q.cfg <= `SARSEQ_RST_CFG;
      st_q.pair_cfg <= `SARSEQ_RST_PAIR;
      st_q.chan_addr <= `SARSEQ_RST_CHSEL;
    end else begin
      st_q <= st_d;
    end
  end
  // outputs straight from flops
  assign sfr_rdata_o = st_q.rdata;
  assign analog_enable_o = st_q.analog_en;
  assign track_o = st_q.track;
  assign convert_o = st_q.convert;
  assign sar_tick_o = tick;
  assign mux_pos_o = st_q.mux_pos;
  assign mux_neg_o = st_q.mux_neg;
  assign mux_diff_o = st_q.mux_diff;
  assign mux_temp_o = st_q.mux_temp;
  assign pga_gain_o = st_q.cfg[`SARSEQ_CFG_GAIN_HI:0];
  assign conv_irq_o = st_q.irq;
  assign conv_busy_o = st_q.busy_out;
  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_track_tick3;
    (st_q.state == ST_TRACK) && tick && (st_q.cnt == 5'h02);
  endsequence
  sequence s_conv_entry;
    st_q.state == ST_CONV;
  endsequence
  property p_src_t3;
    (st_q.state == ST_IDLE && st_q.converter_enable && !st_q.track_mode_sel
      && st_q.start_src == `SARSEQ_SRC_T3 && timer3_ovf_i) |=> s_conv_entry ##1 conv_busy_o;
  endproperty
  a_src_t3: assert property (p_src_t3) else $error("timer 3 start not taken");
  property p_done_on_fall;
    $fell(busy) |-> st_q.conv_done_flag;
  endproperty
  a_done_on_fall: assert property (p_done_on_fall) else $error("done flag not set");
  property p_irq;
    st_q.conv_done_flag && irq_enable_i |=> conv_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");
  // a disable in mid-track is a legal abort, so only enabled tracking must hold
  property p_track_hold;
    (st_q.state == ST_TRACK && st_q.converter_enable && !(tick && st_q.cnt == 5'h02))
      |=> st_q.state == ST_TRACK;
  endproperty
  a_track_hold: assert property (p_track_hold) else $error("tracking cut short");
  property p_track_end;
    st_q.converter_enable ##0 s_track_tick3 |=> s_conv_entry;
  endproperty
  a_track_end: assert property (p_track_end) else $error("no conversion after tracking");
  property p_ext_low_power;
    (st_q.state == ST_IDLE && st_q.converter_enable && st_q.track_mode_sel
      && st_q.start_src == `SARSEQ_SRC_EXT && ext_rise) |=> s_conv_entry;
  endproperty
  a_ext_low_power: assert property (p_ext_low_power) else $error("pin edge not converted");
  property p_continuous;
    (st_q.state == ST_IDLE && st_q.converter_enable && !st_q.track_mode_sel && !standby_i)
      |=> track_o;
  endproperty
  a_continuous: assert property (p_continuous) else $error("idle tracking missing");
  property p_standby;
    standby_i |=> !track_o;
  endproperty
  a_standby: assert property (p_standby) else $error("tracking during standby");
  property p_mux_upper;
    sfr_rd_i && (sfr_addr_i == `SARSEQ_ADDR_PAIR || sfr_addr_i == `SARSEQ_ADDR_CHSEL)
      |=> sfr_rdata_o[7:4] == 4'h0;
  endproperty
  a_mux_upper: assert property (p_mux_upper) else $error("upper mux bits not zero");
  property p_ljst_low;
    sfr_rd_i && sfr_addr_i == `SARSEQ_ADDR_RESL && st_q.left_justify
      |=> sfr_rdata_o[3:0] == 4'h0;
  endproperty
  a_ljst_low: assert property (p_ljst_low) else $error("left justified low nibble");
  property p_temp;
    st_q.chan_addr[3] |=> mux_temp_o && mux_pos_o == `SARSEQ_MUX_TEMP;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature sensor not routed");
  property p_shutdown;
    !st_q.converter_enable |=> !analog_enable_o && !track_o ##1 !conv_busy_o;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("analog active while disabled");
endmodule // sarseq_top

//--- test/sarseq_cpu_model.sv
// processor core model driving the special function register bus
`include "sarseq_consts.svh"
module sarseq_cpu_model (
  // system
  input wire logic clk_sys_i,
  // register bus
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // bus idle at time zero
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_wdata_o = 8'h00;
  end
  // ==========================================
  // one write, strobe held over a single rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    sfr_addr_o <= a;
    sfr_wdata_o <= d;
    sfr_wr_o <= 1'b1;
    @(negedge clk_sys_i);
    sfr_wr_o <= 1'b0;
    sfr_addr_o <= ~a; // released lines never show the stale value
    sfr_wdata_o <= ~d;
  endtask
  // one read; data is registered, so it is taken a full cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_i);
    sfr_addr_o <= a;
    sfr_rd_o <= 1'b1;
    @(negedge clk_sys_i);
    sfr_rd_o <= 1'b0;
    sfr_addr_o <= ~a;
    @(negedge clk_sys_i);
    d = sfr_rdata_i;
  endtask
  // ==========================================
  // software start: clear flag, set busy, poll flag with a bounded count
  task automatic sw_convert(input logic [7:0] ctrl, output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    wr(`SARSEQ_ADDR_CTRL, ctrl);
    wr(`SARSEQ_ADDR_CTRL, ctrl | 8'h10);
    for (int i = 0; i < 60 && ok !== 1'b1; i++) begin
      rd(`SARSEQ_ADDR_CTRL, v);
      ok = v[`SARSEQ_CTRL_DONE];
    end
  endtask
endmodule // sarseq_cpu_model

//--- test/sar_adc_sequencer_mux_ctrl_bench.sv
// self-checking bench of the converter sequencer and input mux control
`include "sarseq_consts.svh"
module sar_adc_sequencer_mux_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = `SARSEQ_ADDR_CTRL;
  localparam logic [7:0] RH = `SARSEQ_ADDR_RESH;
  localparam logic [7:0] RL = `SARSEQ_ADDR_RESL;
  localparam int NCONV = `SARSEQ_CONV_SAR_CLKS;
  localparam int NTRK = `SARSEQ_TRACK_SAR_CLKS;
  localparam int PER = 1; // period field, converter clock = system clock / 2
  // ==========================================
  // stimulus and observed signals
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic sfr_wr, sfr_rd;
  logic timer3_ovf = 1'b0;
  logic timer2_ovf = 1'b0;
  logic ext_pin = 1'b0;
  logic standby = 1'b0;
  logic irq_en = 1'b1;
  logic [11:0] conv_data = 12'ha5c;
  logic analog_enable_o, track_o, convert_o, sar_tick_o, mux_diff_o, mux_temp_o;
  logic conv_irq_o, conv_busy_o;
  logic [3:0] mux_pos_o, mux_neg_o;
  logic [2:0] pga_gain_o;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int busy_cyc = 0;
  int tick_cnt = 0;
  int overlap = 0;
  // ==========================================
  // clock
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  sarseq_cpu_model cpu (.clk_sys_i(clk_sys_i), .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr),
    .sfr_rd_o(sfr_rd), .sfr_wdata_o(sfr_wdata), .sfr_rdata_i(sfr_rdata));
  sarseq_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
    .timer3_ovf_i(timer3_ovf), .timer2_ovf_i(timer2_ovf), .ext_convert_start_i(ext_pin),
    .standby_i(standby), .irq_enable_i(irq_en), .conv_data_i(conv_data),
    .analog_enable_o(analog_enable_o), .track_o(track_o), .convert_o(convert_o),
    .sar_tick_o(sar_tick_o), .mux_pos_o(mux_pos_o), .mux_neg_o(mux_neg_o),
    .mux_diff_o(mux_diff_o), .mux_temp_o(mux_temp_o), .pga_gain_o(pga_gain_o),
    .conv_irq_o(conv_irq_o), .conv_busy_o(conv_busy_o));
  // ==========================================
  // port monitors and hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (conv_busy_o === 1'b1) busy_cyc++;
    if (sar_tick_o === 1'b1) tick_cnt++;
    if (track_o === 1'b1 && convert_o === 1'b1) overlap++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  // ==========================================
  // comparison helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu.rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  // bounded wait until busy reaches a level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy_o !== lvl && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk({15'h0, conv_busy_o}, {15'h0, lvl});
  endtask
  // one start event: 1 timer 3, 2 pin rise (pin stays high), 3 timer 2
  task automatic fire(input int k);
    @(negedge clk_sys_i);
    if (k == 1) timer3_ovf = 1'b1;
    if (k == 2) ext_pin = 1'b1;
    if (k == 3) timer2_ovf = 1'b1;
    @(negedge clk_sys_i);
    timer3_ovf = 1'b0;
    timer2_ovf = 1'b0;
  endtask
  // expected {temp, diff, neg, pos} for a pair setting and channel code
  function automatic logic [15:0] mux_exp(input logic [3:0] pr, input logic [3:0] a);
    if (a[3]) return 16'h0208;
    if (pr[a[2:1]]) return {6'h00, 2'b01, 1'b0, a[2:1], 1'b1, 1'b0, a[2:1], 1'b0};
    return {12'h000, 1'b0, a[2:0]};
  endfunction
  // software conversion; busy spans the start cycle before the divider's first count
  task automatic sw_conv(input logic [7:0] ctrl, input int ticks);
    logic ok;
    busy_cyc = 0;
    tick_cnt = 0;
    cpu.sw_convert(ctrl, ok);
    chk({15'h0, ok}, 16'h1);
    chk(busy_cyc[15:0], 16'(ticks * (PER + 1) + 1));
    chk(tick_cnt[15:0], 16'(ticks));
  endtask
  // ==========================================
  // verdict, the single place where the run ends
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rdchk(`SARSEQ_ADDR_PAIR, 8'h00);
    rdchk(`SARSEQ_ADDR_CHSEL, 8'h00);
    rdchk(`SARSEQ_ADDR_CFG, 8'hf8);
    rdchk(CTL, 8'h00);
    rdchk(8'h00, 8'h00);
    chk({15'h0, analog_enable_o}, 16'h0);
    // every pair setting against every channel code, junk in the upper bits
    for (int c = 0; c < 16; c++) begin
      cpu.wr(`SARSEQ_ADDR_PAIR, {4'hf, c[3:0]});
      for (int a = 0; a < 16; a++) begin
        cpu.wr(`SARSEQ_ADDR_CHSEL, {4'ha, a[3:0]});
        repeat (2) @(negedge clk_sys_i);
        chk({6'h00, mux_temp_o, mux_diff_o, mux_neg_o, mux_pos_o}, mux_exp(c[3:0], a[3:0]));
      end
    end
    rdchk(`SARSEQ_ADDR_PAIR, 8'h0f);
    rdchk(`SARSEQ_ADDR_CHSEL, 8'h0f);
    cpu.wr(`SARSEQ_ADDR_PAIR, 8'h00);
    cpu.wr(`SARSEQ_ADDR_CHSEL, 8'h00);
    cpu.wr(`SARSEQ_ADDR_CFG, {5'(PER), 3'h2});
    rdchk(`SARSEQ_ADDR_CFG, {5'(PER), 3'h2});
    chk({13'h0, pga_gain_o}, 16'h2);
    cpu.wr(CTL, 8'h82);
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0, analog_enable_o}, 16'h1);
    rdchk(CTL, 8'h82);
    // single-ended result in both justifications, high result reg read-only
    sw_conv(8'h80, NCONV);
    rdchk(RH, 8'h0a);
    rdchk(RL, 8'h5c);
    cpu.wr(CTL, 8'h81);
    cpu.wr(RH, 8'h00);
    rdchk(RH, 8'ha5);
    rdchk(RL, 8'hc0);
    // differential pair gives a sign-extended result
    cpu.wr(`SARSEQ_ADDR_PAIR, 8'h01);
    conv_data = 12'h8f3;
    sw_conv(8'h80, NCONV);
    rdchk(RH, 8'hf8);
    rdchk(RL, 8'hf3);
    cpu.wr(`SARSEQ_ADDR_PAIR, 8'h00);
    // hardware sources: wrong sources and a busy write must not start
    for (int s = 1; s < 4; s++) begin
      cpu.wr(CTL, 8'h90 | {4'h0, s[1:0], 2'b00});
      for (int k = 1; k < 4; k++) begin
        if (k != s) fire(k);
      end
      ext_pin = 1'b0;
      repeat (10) @(negedge clk_sys_i);
      chk({15'h0, conv_busy_o}, 16'h0);
      fire(s);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rdchk(CTL, 8'ha0 | {4'h0, s[1:0], 2'b00});
      ext_pin = 1'b0;
    end
    chk({15'h0, conv_irq_o}, 16'h1);
    irq_en = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0, conv_irq_o}, 16'h0);
    // continuous tracking when idle, cut by standby
    cpu.wr(CTL, 8'h80);
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0, track_o}, 16'h1);
    standby = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({15'h0, track_o}, 16'h0);
    standby = 1'b0;
    // low-power mode: three tracking ticks precede the conversion
    cpu.wr(CTL, 8'hc0);
    fork
      sw_conv(8'hc0, NTRK + NCONV);
      begin
        wait_busy(1'b1);
        chk({14'h0, track_o, convert_o}, 16'h2);
      end
    join
    chk({15'h0, track_o}, 16'h0);
    // low-power mode with pin source tracks only while the pin is low
    cpu.wr(CTL, 8'hc8);
    repeat (8) @(negedge clk_sys_i);
    chk({15'h0, track_o}, 16'h1);
    ext_pin = 1'b1;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk({15'h0, track_o}, 16'h0);
    ext_pin = 1'b0;
    // disable shuts the analog parts down
    cpu.wr(CTL, 8'h00);
    repeat (2) @(negedge clk_sys_i);
    chk({14'h0, analog_enable_o, track_o}, 16'h0);
    chk(overlap[15:0], 16'h0);
    print_verdict();
  end
endmodule // sar_adc_sequencer_mux_ctrl_bench
